// ===== src/txc_consts.svh
// offsets, field positions and reset values of the per-port transmit control registers
`ifndef TXC_CONSTS_SVH
`define TXC_CONSTS_SVH
`define TXC_ADDR_W        12
`define TXC_PORT_STRIDE   12'h200
`define TXC_NUM_PORTS     4
`define TXC_OFF_CTRL4     9'h186
`define TXC_OFF_FIFO      9'h187
`define TXC_OFF_IBO       9'h188
`define TXC_OFF_MONSEL    9'h189
`define TXC_OFF_EXP       9'h18A
`define TXC_OFF_BERTSUP   9'h18B
`define TXC_OFF_HDLCSUP   9'h18D
`define TXC_OFF_SYNC      9'h18E
`define TXC_OFF_CHSEL1    9'h1DC
`define TXC_OFF_CHSEL2    9'h1DD
`define TXC_OFF_CHSEL3    9'h1DE
`define TXC_OFF_CHSEL4    9'h1DF
`define TXC_RST           8'h00
`define TXC_MASK_FIFO     8'h03
`define TXC_MASK_IBO      8'h18
`define TXC_MASK_MONSEL   8'h1F
`define TXC_MASK_EXP      8'hC7
`define TXC_MASK_SYNC     8'h0F
`define TXC_MASK_ALL      8'hFF
`define TXC_INV_NONE      2'h0
`define TXC_INV_FRAMING   2'h1
`define TXC_INV_SIGNALING 2'h2
`define TXC_INV_PAYLOAD   2'h3
`define TXC_MW_ULAW       8'h1E
`define TXC_MW_ALAW       8'h34
`endif

// ===== src/txc_pkg.sv
// types for the per-port transmit control registers
package txc_pkg;
    typedef enum logic [3:0] {
        TXC_LOOP_5   = 4'h1,
        TXC_LOOP_6_3 = 4'h2,
        TXC_LOOP_7   = 4'h4,
        TXC_LOOP_16  = 4'h8
    } txc_loop_len_t;

    typedef struct packed {
        logic                milliwatt_law_select;
        logic [7:0]          milliwatt_code;
        logic [1:0]          tx_inversion_select;
        logic                inv_framing;
        logic                inv_signaling;
        logic                inv_payload;
        logic                jammed_bit_suppress_enable;
        logic                remote_alarm_mode;
        logic                remote_alarm_ci;
        logic                ais_pattern_mode;
        logic                ais_ci;
        txc_loop_len_t       loop_code_length;
        logic [5:0]          fifo_low_watermark_bytes;
        logic                interleave_enable;
        logic                interleave_channel;
        logic                interleave_frame;
        logic [4:0]          monitor_channel_select;
        logic [5:0]          monitor_channel_number;
        logic                hdlc_wide_enable;
        logic                hdlc_wide_timeslots;
        logic                hdlc_wide_overhead;
        logic [31:0]         hdlc_channel_select_word;
        logic [7:0]          hdlc_bit_use;
        logic [4:0]          hdlc_sa_use;
        logic                bert_port_active;
        logic                bert_to_line;
        logic                bert_to_receive_serial_output;
        logic                bert_fbit_use;
        logic [7:0]          bert_bit_use;
        logic [3:0]          sync_control;
    } txc_cfg_t;
endpackage

// ===== src/txc_regs.sv
// per-port transmit control register bank with decoded controls for four ports
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "txc_consts.svh"

// Function
// - each register exists four times, port copy at base plus 200h times index
// - milliwatt law bit picks mu-law code at 0, A-law at 1
// - inversion field: none, framing, signaling or payload bits
// - jammed suppression forces bit 8 in enabled channels, bit 7 in signaling frames
// - remote alarm mode picks normal pattern at 0, RAI-CI at 1 in ESF
// - AIS mode sends unframed all ones at 0, AIS-CI at 1
// - loop code length field selects 5, 6/3, 7 or 16/8/4/2/1 bits
// - FIFO low watermark field selects 4, 16, 32 or 48 bytes
// - interleave select bit: channel interleave at 0, frame interleave at 1
// - interleaved backplane runs only while interleave enable is 1
// - monitor field code 0 picks channel 1, code 31 picks channel 32
// - HDLC-256 mode maps to timeslots at 0, FDL or Sa bits at 1
// - HDLC-256 controller active only while its enable bit is 1
// - BERT direction routes to transmit path at 0, receive serial output at 1
// - T1 BERT skips F-bit at 0, includes F-bit at 1
// - BERT port operates only while its port enable bit is 1
// - BERT suppress bit 7 is channel MSB, bit 0 LSB; set bit blocks use
// - any of 32 channel select bits enables HDLC clock in that channel
// - HDLC suppress bits exclude channel bits; low five also suppress Sa8..Sa4
module txc_regs #(
    parameter int NPORTS = `TXC_NUM_PORTS
) (
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       nrst,
    // register port
    input  wire logic [`TXC_ADDR_W-1:0]     reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [7:0]                 reg_rdata,
    // datapath status shown in the monitor register
    input  wire logic [NPORTS*8-1:0]        channel_monitor_data,
    // decoded controls, one struct per port
    output txc_pkg::txc_cfg_t [NPORTS-1:0]  cfg
);

    // register indices within one port
    localparam int NREG = 12;
    localparam int IX_CTRL4 = 0;
    localparam int IX_FIFO = 1;
    localparam int IX_IBO = 2;
    localparam int IX_MONSEL = 3;
    localparam int IX_EXP = 4;
    localparam int IX_BERTSUP = 5;
    localparam int IX_HDLCSUP = 6;
    localparam int IX_SYNC = 7;
    localparam int IX_CH1 = 8;

    // the monitor data register sits one above the BERT suppress offset,
    // read only; chosen offset in the unused gap of the port window
    localparam logic [8:0] OFF_MONDATA = 9'h18C;

    logic [7:0] regs_q [NPORTS][NREG];
    logic [7:0] reg_rdata_q;
    txc_pkg::txc_cfg_t [NPORTS-1:0] cfg_q;

    // port index and in-port offset; port n lives at base + 200h*n
    wire logic [2:0] port_idx = reg_addr[11:9];
    wire logic [8:0] port_off = reg_addr[8:0];
    wire logic       port_ok = (32'(port_idx) < NPORTS);

    // offset decode to register index, writable mask per register
    logic [3:0] hit_ix;
    logic       hit;
    logic [7:0] hit_mask;
    always_comb begin
        hit = 1'b1;
        hit_ix = 4'h0;
        hit_mask = `TXC_MASK_ALL;
        case (port_off)
            `TXC_OFF_CTRL4: hit_ix = 4'(IX_CTRL4);
            `TXC_OFF_FIFO: begin
                hit_ix = 4'(IX_FIFO);
                hit_mask = `TXC_MASK_FIFO;
            end
            `TXC_OFF_IBO: begin
                hit_ix = 4'(IX_IBO);
                hit_mask = `TXC_MASK_IBO;
            end
            `TXC_OFF_MONSEL: begin
                hit_ix = 4'(IX_MONSEL);
                hit_mask = `TXC_MASK_MONSEL;
            end
            `TXC_OFF_EXP: begin
                hit_ix = 4'(IX_EXP);
                hit_mask = `TXC_MASK_EXP;
            end
            `TXC_OFF_BERTSUP: hit_ix = 4'(IX_BERTSUP);
            `TXC_OFF_HDLCSUP: hit_ix = 4'(IX_HDLCSUP);
            `TXC_OFF_SYNC: begin
                hit_ix = 4'(IX_SYNC);
                hit_mask = `TXC_MASK_SYNC;
            end
            `TXC_OFF_CHSEL1: hit_ix = 4'(IX_CH1);
            `TXC_OFF_CHSEL2: hit_ix = 4'(IX_CH1 + 1);
            `TXC_OFF_CHSEL3: hit_ix = 4'(IX_CH1 + 2);
            `TXC_OFF_CHSEL4: hit_ix = 4'(IX_CH1 + 3);
            default: hit = 1'b0;
        endcase
    end

    wire logic do_wr = reg_wr && hit && port_ok;
    wire logic rd_mon = (port_off == OFF_MONDATA) && port_ok;

    // read data: unmapped offsets and unused ports answer zero
    wire logic [7:0] rd_reg = regs_q[port_idx[1:0]][hit_ix];
    wire logic [7:0] rd_mon_val = channel_monitor_data[port_idx[1:0]*8 +: 8];
    wire logic [7:0] rd_val = (hit && port_ok) ? rd_reg :
                              (rd_mon ? rd_mon_val : `TXC_RST);

    // register storage; writes land only on defined bit positions
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int p = 0; p < NPORTS; p++) begin
                for (int r = 0; r < NREG; r++) begin
                    regs_q[p][r] <= `TXC_RST;
                end
            end
        end else if (do_wr) begin
            regs_q[port_idx[1:0]][hit_ix] <= reg_wdata & hit_mask;
        end
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_q <= `TXC_RST;
        end else begin
            reg_rdata_q <= reg_rd ? rd_val : `TXC_RST;
        end
    end
    assign reg_rdata = reg_rdata_q;

    // decode each port's raw bits into datapath controls
    txc_pkg::txc_cfg_t [NPORTS-1:0] cfg_d;
    for (genvar p = 0; p < NPORTS; p++) begin : g_port
        wire logic [7:0] c4 = regs_q[p][IX_CTRL4];
        wire logic [7:0] ex = regs_q[p][IX_EXP];
        wire logic [7:0] ib = regs_q[p][IX_IBO];
        wire logic [7:0] hs = regs_q[p][IX_HDLCSUP];
        wire logic [1:0] inv = c4[6:5];
        wire logic [1:0] lc = c4[1:0];
        wire logic [1:0] wm = regs_q[p][IX_FIFO][1:0];
        txc_pkg::txc_loop_len_t llen;
        logic [5:0] wm_bytes;

        // loop code length and watermark tables
        always_comb begin
            case (lc)
                2'h0: llen = txc_pkg::TXC_LOOP_5;
                2'h1: llen = txc_pkg::TXC_LOOP_6_3;
                2'h2: llen = txc_pkg::TXC_LOOP_7;
                default: llen = txc_pkg::TXC_LOOP_16;
            endcase
            case (wm)
                2'h0: wm_bytes = 6'h04;
                2'h1: wm_bytes = 6'h10;
                2'h2: wm_bytes = 6'h20;
                default: wm_bytes = 6'h30;
            endcase
        end

        always_comb begin
            cfg_d[p] = '0;
            cfg_d[p].milliwatt_law_select = c4[7];
            // code byte inserted in milliwatt-enabled channels
            cfg_d[p].milliwatt_code = c4[7] ? `TXC_MW_ALAW : `TXC_MW_ULAW;
            cfg_d[p].tx_inversion_select = inv;
            cfg_d[p].inv_framing = (inv == `TXC_INV_FRAMING);
            cfg_d[p].inv_signaling = (inv == `TXC_INV_SIGNALING);
            cfg_d[p].inv_payload = (inv == `TXC_INV_PAYLOAD);
            // the framer applies it per channel enable and in signaling frames
            cfg_d[p].jammed_bit_suppress_enable = c4[4];
            cfg_d[p].remote_alarm_mode = c4[3];
            cfg_d[p].remote_alarm_ci = c4[3];
            cfg_d[p].ais_pattern_mode = c4[2];
            cfg_d[p].ais_ci = c4[2];
            cfg_d[p].loop_code_length = llen;
            cfg_d[p].fifo_low_watermark_bytes = wm_bytes;
            cfg_d[p].interleave_enable = ib[3];
            cfg_d[p].interleave_channel = ib[3] & ~ib[4];
            cfg_d[p].interleave_frame = ib[3] & ib[4];
            cfg_d[p].monitor_channel_select = regs_q[p][IX_MONSEL][4:0];
            // channel numbers are one-based
            cfg_d[p].monitor_channel_number =
                {1'b0, regs_q[p][IX_MONSEL][4:0]} + 6'h01;
            cfg_d[p].hdlc_wide_enable = ex[6];
            cfg_d[p].hdlc_wide_timeslots = ex[6] & ~ex[7];
            cfg_d[p].hdlc_wide_overhead = ex[6] & ex[7];
            // channel gating only matters while mapped to timeslots
            cfg_d[p].hdlc_channel_select_word = (ex[6] & ~ex[7]) ?
                {regs_q[p][IX_CH1+3], regs_q[p][IX_CH1+2],
                 regs_q[p][IX_CH1+1], regs_q[p][IX_CH1]} : 32'h0000_0000;
            cfg_d[p].hdlc_bit_use = ~hs;
            // bit 4 pairs with Sa4, bit 0 with Sa8; index k is Sa(k+4)
            cfg_d[p].hdlc_sa_use = {~hs[0], ~hs[1], ~hs[2], ~hs[3], ~hs[4]};
            cfg_d[p].bert_port_active = ex[0];
            cfg_d[p].bert_to_line = ex[0] & ~ex[2];
            cfg_d[p].bert_to_receive_serial_output = ex[0] & ex[2];
            cfg_d[p].bert_fbit_use = ex[0] & ex[1];
            cfg_d[p].bert_bit_use = ex[0] ? ~regs_q[p][IX_BERTSUP] : 8'h00;
            cfg_d[p].sync_control = regs_q[p][IX_SYNC][3:0];
        end
    end

    // controls leave through flip-flops, one cycle after a write
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_d;
        end
    end
    assign cfg = cfg_q;

endmodule
`default_nettype wire

// ===== verification/txc_regs_props.sv
// checker: decode and timing relations of the transmit control register bank
`timescale 1ns/1ps
`default_nettype none
`include "txc_consts.svh"
module txc_regs_props #(
    parameter int NPORTS = 4
) (
    // clock and reset
    input wire logic                          core_clk,
    input wire logic                          nrst,
    // register port
    input wire logic [11:0]                   reg_addr,
    input wire logic [7:0]                    reg_wdata,
    input wire logic                          reg_wr,
    input wire logic                          reg_rd,
    input wire logic [7:0]                    reg_rdata,
    // monitor data and decoded controls
    input wire logic [NPORTS*8-1:0]           channel_monitor_data,
    input wire txc_pkg::txc_cfg_t [NPORTS-1:0] cfg
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // a write into a port-0 register; cfg shows it two edges later
    sequence wr0(logic [8:0] o);
        reg_wr && reg_addr == {3'h0, o};
    endsequence
    // decoded code lags reset release by one edge, hence the past guard
    law_code_a: assert property ($past(nrst) |-> cfg[0].milliwatt_code ==
        (cfg[0].milliwatt_law_select ? `TXC_MW_ALAW : `TXC_MW_ULAW)) else $error("milliwatt code");
    inv_decode_a: assert property ({1'b0, cfg[0].inv_payload, cfg[0].inv_signaling,
        cfg[0].inv_framing} == (4'h1 << cfg[0].tx_inversion_select) >> 1)
        else $error("inversion");
    loop_len_a: assert property (wr0(`TXC_OFF_CTRL4) |-> ##2
        cfg[0].loop_code_length == 4'h1 << $past(reg_wdata[1:0], 2)) else $error("loop length");
    watermark_a: assert property (wr0(`TXC_OFF_FIFO) |-> ##2
        cfg[0].fifo_low_watermark_bytes ==
        (($past(reg_wdata[1:0], 2) == 2'h0) ? 6'h04 : {$past(reg_wdata[1:0], 2), 4'h0}))
        else $error("watermark");
    monitor_num_a: assert property ($past(nrst) |-> cfg[0].monitor_channel_number ==
        {1'b0, cfg[0].monitor_channel_select} + 6'h01) else $error("monitor channel");
    interleave_a: assert property (wr0(`TXC_OFF_IBO) |-> ##2
        cfg[0].interleave_frame == ($past(reg_wdata[4], 2) && $past(reg_wdata[3], 2)) &&
        cfg[0].interleave_channel == (!$past(reg_wdata[4], 2) && $past(reg_wdata[3], 2)))
        else $error("interleave");
    expansion_a: assert property (wr0(`TXC_OFF_EXP) |-> ##2
        cfg[0].hdlc_wide_enable == $past(reg_wdata[6], 2) &&
        cfg[0].bert_port_active == $past(reg_wdata[0], 2)) else $error("expansion enables");
    // route follows the direction bit of the written byte, gated by the port enable
    bert_route_a: assert property (wr0(`TXC_OFF_EXP) |-> ##2
        cfg[0].bert_to_receive_serial_output ==
        ($past(reg_wdata[2], 2) && $past(reg_wdata[0], 2)) &&
        cfg[0].bert_to_line == (!$past(reg_wdata[2], 2) && $past(reg_wdata[0], 2)))
        else $error("bert route");
    monitor_read_a: assert property (reg_rd && reg_addr == 12'h38C |=>
        reg_rdata == $past(channel_monitor_data[15:8])) else $error("monitor read");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
endmodule
bind txc_regs txc_regs_props #(.NPORTS(NPORTS)) txc_regs_props_i (.core_clk(core_clk),
    .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .channel_monitor_data(channel_monitor_data),
    .cfg(cfg));
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the transmit control register bank
`timescale 1ns/1ps
`default_nettype none
`include "txc_consts.svh"
`define CK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_top;
    logic                    core_clk;
    logic                    nrst;
    logic [11:0]             reg_addr;
    logic [7:0]              reg_wdata;
    logic                    reg_wr;
    logic                    reg_rd;
    logic [7:0]              reg_rdata;
    logic [31:0]             mon_data;
    txc_pkg::txc_cfg_t [3:0] cfg;
    int                      err_count;
    int                      check_count;
    logic                    pend;
    logic [7:0]              pend_exp;
    logic [8:0]              offs [12] = '{`TXC_OFF_CTRL4, `TXC_OFF_FIFO, `TXC_OFF_IBO,
        `TXC_OFF_MONSEL, `TXC_OFF_EXP, `TXC_OFF_BERTSUP, `TXC_OFF_HDLCSUP, `TXC_OFF_SYNC,
        `TXC_OFF_CHSEL1, `TXC_OFF_CHSEL2, `TXC_OFF_CHSEL3, `TXC_OFF_CHSEL4};
    logic [7:0]              msk [12] = '{8'hFF, `TXC_MASK_FIFO, `TXC_MASK_IBO, `TXC_MASK_MONSEL,
        `TXC_MASK_EXP, 8'hFF, 8'hFF, `TXC_MASK_SYNC, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

    txc_regs #(.NPORTS(4)) txc_regs_i (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .channel_monitor_data(mon_data), .cfg(cfg));

    // free-running core clock, 8 ns period
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // one bus cycle; checks the read data of the call before, which stands one cycle only
    task automatic bus(input logic w, r, input logic [11:0] a, input logic [7:0] d, e);
        @(posedge core_clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        #1;
        if (pend) `CK(reg_rdata, pend_exp) else `CK(reg_rdata, 8'h00)
        pend = r;
        pend_exp = e;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d, 8'h00);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        bus(1'b0, 1'b1, a, 8'h00, e);
    endtask
    task automatic nop(); bus(1'b0, 1'b0, 12'h000, 8'h00, 8'h00); endtask
    // distinct fill byte per port and register, so a crossed copy shows up
    function automatic logic [7:0] pat(input int p, i);
        return 8'(8'hA5 + p * 8'h13 + i * 8'h07);
    endfunction

    // reset is asynchronous; strobes are already low when it is entered
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
    endtask

    // every register and the loop, watermark, monitor, milliwatt, HDLC and BERT use defaults of all four ports
    task automatic chk_dflt();
        for (int p = 0; p < 4; p++) begin
            for (int i = 0; i < 12; i++) rd({3'(p), offs[i]}, 8'h00);
            `CK(cfg[p].loop_code_length, txc_pkg::TXC_LOOP_5);
            `CK(cfg[p].fifo_low_watermark_bytes, 6'h04);
            `CK(cfg[p].monitor_channel_number, 6'h01);
            `CK(cfg[p].milliwatt_code, `TXC_MW_ULAW);
            `CK({cfg[p].hdlc_bit_use, cfg[p].hdlc_sa_use}, 13'h1FFF);
            `CK({cfg[p].hdlc_channel_select_word, cfg[p].bert_bit_use}, 40'h0);
        end
        nop();
        $display("test defaults done");
    endtask

    // per-port copies, masking of unused bits, unmapped places, read-only monitor
    task automatic t_regs();
        for (int p = 0; p < 4; p++)
            for (int i = 0; i < 12; i++) wr({3'(p), offs[i]}, pat(p, i));
        wr({3'h4, offs[0]}, 8'hFF);
        wr(12'h18F, 8'hFF);
        for (int p = 0; p < 4; p++)
            for (int i = 0; i < 12; i++) rd({3'(p), offs[i]}, pat(p, i) & msk[i]);
        rd({3'h4, offs[0]}, 8'h00);
        rd(12'h18F, 8'h00);
        for (int p = 0; p < 4; p++) begin
            wr({3'(p), 9'h18C}, 8'hFF);
            rd({3'(p), 9'h18C}, mon_data[p*8+:8]);
        end
        nop();
        $display("test registers done");
    endtask

    // four codes of every field on port 0; undefined bits set alongside, except in the sync register
    task automatic t_fields();
        logic [1:0]        k;
        logic [4:0]        mc;
        logic [7:0]        dv [12];
        txc_pkg::txc_cfg_t cf;
        for (int n = 0; n < 4; n++) begin
            k = 2'(n);
            mc = {k, k, k[0]};
            dv = '{{k[0], k, k[0], k[1], k[0], k}, {6'h3F, k}, {3'h7, k, 3'h7}, {3'h7, mc},
                {k, 3'h7, k[1], k[0], k[0]}, 8'hC3 >> k, 8'h1B << k, 8'(n * 5),
                8'h11 ^ k, 8'h22 ^ k, 8'h44 ^ k, 8'h88 ^ k};
            for (int i = 0; i < 12; i++) wr({3'h0, offs[i]}, dv[i]);
            nop();
            nop();
            cf = cfg[0];
            `CK(cf.milliwatt_law_select, k[0]);
            `CK(cf.milliwatt_code, k[0] ? `TXC_MW_ALAW : `TXC_MW_ULAW);
            `CK(cf.tx_inversion_select, k);
            `CK({cf.inv_payload, cf.inv_signaling}, {k == 2'h3, k == 2'h2});
            `CK(cf.inv_framing, k == 2'h1);
            `CK(cf.jammed_bit_suppress_enable, k[0]);
            `CK({cf.remote_alarm_mode, cf.remote_alarm_ci}, {k[1], k[1]});
            `CK({cf.ais_pattern_mode, cf.ais_ci}, {k[0], k[0]});
            `CK(cf.loop_code_length, 4'h1 << k);
            `CK(cf.fifo_low_watermark_bytes, (k == 2'h0) ? 6'h04 : {k, 4'h0});
            `CK(cf.interleave_frame, k[0] & k[1]);
            `CK(cf.interleave_channel, k[0] & ~k[1]);
            `CK(cf.interleave_enable, k[0]);
            `CK(cf.monitor_channel_select, mc);
            `CK(cf.monitor_channel_number, {1'b0, mc} + 6'h01);
            `CK({cf.hdlc_wide_enable, cf.bert_port_active}, {k[0], k[0]});
            `CK(cf.bert_bit_use, k[0] ? ~dv[5] : 8'h00);
            // the select word is gated to zero unless the wide controller maps to timeslots
            `CK(cf.hdlc_channel_select_word[31:16], (k == 2'h1) ? {dv[11], dv[10]} : 16'h0);
            `CK(cf.hdlc_channel_select_word[15:0], (k == 2'h1) ? {dv[9], dv[8]} : 16'h0);
            `CK(cf.hdlc_bit_use, ~dv[6]);
            `CK(cf.hdlc_sa_use, ~{dv[6][0], dv[6][1], dv[6][2], dv[6][3], dv[6][4]});
            `CK(cf.sync_control, dv[7][3:0]);
            `CK(cf.bert_fbit_use, k[0]);
            if (k[0]) begin
                `CK({cf.hdlc_wide_timeslots, cf.hdlc_wide_overhead}, {~k[1], k[1]});
                `CK(cf.bert_to_receive_serial_output, k[1]);
                `CK(cf.bert_to_line, ~k[1]);
            end
        end
        $display("test fields done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // main sequence, with a second reset in mid-run
    initial begin
        {nrst, reg_wr, reg_rd, pend} = 4'h0;
        {reg_addr, reg_wdata, pend_exp} = 28'h0;
        mon_data = 32'hC35A_96E1;
        {err_count, check_count} = 64'h0;
        do_reset();
        chk_dflt();
        t_regs();
        t_fields();
        do_reset();
        chk_dflt();
        tally_and_finish();
    end

    // watchdog: the sequence needs well under 10 us
    initial begin
        #50us;
        err_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
